//--- hdl/cxd_top.sv
`timescale 1ns/100ps
// What this block does
// - undefined primary opcode raises reserved fault
// - undefined function field in register group faults
// - undefined rt subfield in immediate group faults
// - doubleword ops reserved in 32-bit user/supervisor
// - kernel mode always allows doubleword ops
// - reserved fault writes undefined-opcode cause code
// - save return address, branch address in slot
// - true conditional trap raises trap fault
// - signed arithmetic overflow raises overflow fault
// - load/store on watched address raises watch
// - load and store enables qualify watch
// - cache maintenance never raises watch
// - exception level holds watch pending
// - eight interrupt sources use external-event code
// - mask, global enable and levels gate interrupts
// - pending field shows live request state
// - software sets and clears two soft requests
// - parity disable or error level hides cache error
// - coprocessor fault records referenced unit number
module cxd_top
(
	// clock and reset
	input  wire logic                MCLK_I,
	input  wire logic                RESETN_I,
	input  wire logic                CE_I,
	// pipeline
	input  wire cxd_pkg::cxd_instr_s INSTR_I,
	input  wire logic                CACHE_ERR_I,
	input  wire logic [4:0]          HW_REQ_I,
	input  wire logic                TIMER_REQ_I,
	// axi4-lite write
	input  wire logic [7:0]          AWADDR_I,
	input  wire logic                AWVALID_I,
	output      logic                AWREADY_O,
	input  wire logic [31:0]         WDATA_I,
	input  wire logic [3:0]          WSTRB_I,
	input  wire logic                WVALID_I,
	output      logic                WREADY_O,
	output      logic [1:0]          BRESP_O,
	output      logic                BVALID_O,
	input  wire logic                BREADY_I,
	// axi4-lite read
	input  wire logic [7:0]          ARADDR_I,
	input  wire logic                ARVALID_I,
	output      logic                ARREADY_O,
	output      logic [31:0]         RDATA_O,
	output      logic [1:0]          RRESP_O,
	output      logic                RVALID_O,
	input  wire logic                RREADY_I,
	// exception outputs
	output      logic                EXC_O,
	output      logic                CACHE_EXC_O,
	output      logic                WATCH_PEND_O
);
	logic [31:0] status;
	logic [31:0] cause;
	logic [31:0] exception_return_address;
	logic [31:0] match_address_low;
	logic [31:0] match_address_high;
	logic        watch_held;
	logic [7:0]  aw_a;
	logic [31:0] w_d;
	logic [3:0]  w_s;
	logic        aw_have;
	logic        w_have;
	logic [31:0] next_rdata;
	logic [7:0]  pending_request_bits;
	logic        undef_op;
	logic        undef_fn;
	logic        undef_rt;
	logic        dword_op;
	logic        dword_bad;
	logic        watch_hit;
	logic        int_take;
	logic        take;
	logic [4:0]  next_code;
	logic [5:0]  op;
	logic [5:0]  fn;
	logic [4:0]  rt;
	logic        mode32;
	logic [31:0] wmask;
	logic        wr_go;

	assign op = INSTR_I.instr[31:26];
	assign fn = INSTR_I.instr[5:0];
	assign rt = INSTR_I.instr[20:16];

	// opcode decode
	always_comb
	begin
		undef_op = 1'b0;
		case (op)
			6'h13, 6'h1C, 6'h1D, 6'h1E, 6'h1F, 6'h32, 6'h3A, 6'h3B, 6'h3E: undef_op = 1'b1;
			default: undef_op = 1'b0;
		endcase
	end

	always_comb
	begin
		undef_fn = 1'b0;
		if (op == 6'h00)
		begin
			case (fn)
				6'h01, 6'h05, 6'h0A, 6'h0B, 6'h0E, 6'h15, 6'h28, 6'h29, 6'h35, 6'h37, 6'h39, 6'h3D:
					undef_fn = 1'b1;
				default: undef_fn = 1'b0;
			endcase
		end
	end

	always_comb
	begin
		undef_rt = 1'b0;
		if (op == 6'h01)
		begin
			case (rt)
				5'h00, 5'h01, 5'h02, 5'h03, 5'h08, 5'h09, 5'h0A, 5'h0B, 5'h0C, 5'h0E,
				5'h10, 5'h11, 5'h12, 5'h13: undef_rt = 1'b0;
				default: undef_rt = 1'b1;
			endcase
		end
	end

	always_comb
	begin
		dword_op = 1'b0;
		case (op)
			6'h18, 6'h19, 6'h1A, 6'h1B, 6'h27, 6'h2C, 6'h2D, 6'h34, 6'h37, 6'h3C, 6'h3F:
				dword_op = 1'b1;
			6'h00:
			begin
				case (fn)
					6'h14, 6'h16, 6'h17, 6'h1C, 6'h1D, 6'h1E, 6'h1F, 6'h2C, 6'h2D, 6'h2E, 6'h2F,
					6'h38, 6'h3A, 6'h3B, 6'h3C, 6'h3E, 6'h3F: dword_op = 1'b1;
					default: dword_op = 1'b0;
				endcase
			end
			default: dword_op = 1'b0;
		endcase
	end

	assign mode32    = ~status[cxd_pkg::ST_UX];
	// kernel never faults doubleword; exl/erl force kernel mode
	assign dword_bad = dword_op & mode32
		& (status[cxd_pkg::ST_KSU +: 2] != 2'(cxd_pkg::M_KERNEL))
		& ~status[cxd_pkg::ST_EXL] & ~status[cxd_pkg::ST_ERL];

	assign watch_hit = (INSTR_I.paddr[35:3] == {match_address_high[3:0], match_address_low[31:3]})
		& ~INSTR_I.is_cache
		& ((INSTR_I.is_load & match_address_low[cxd_pkg::ML_R])
		| (INSTR_I.is_store & match_address_low[cxd_pkg::ML_W]));

	assign pending_request_bits = {TIMER_REQ_I, HW_REQ_I, cause[cxd_pkg::CA_IP +: 2]};
	assign int_take = |(pending_request_bits & status[cxd_pkg::ST_IM +: 8])
		& status[cxd_pkg::ST_IE] & ~status[cxd_pkg::ST_EXL] & ~status[cxd_pkg::ST_ERL];

	// fixed priority: interrupt, cop, reserved, trap, overflow, watch
	always_comb
	begin
		take      = INSTR_I.valid;
		next_code = cxd_pkg::CODE_INT;
		if (int_take)
			next_code = cxd_pkg::CODE_INT;
		else if (INSTR_I.cop_unusable)
			next_code = cxd_pkg::CODE_CPU;
		else if (undef_op | undef_fn | undef_rt | dword_bad)
			next_code = cxd_pkg::CODE_RI;
		else if (INSTR_I.trap_true)
			next_code = cxd_pkg::CODE_TRAP;
		else if (INSTR_I.ovf)
			next_code = cxd_pkg::CODE_OVF;
		else if (watch_hit & ~status[cxd_pkg::ST_EXL])
			next_code = cxd_pkg::CODE_WATCH;
		else
			take = 1'b0;
		if (!INSTR_I.valid)
			take = 1'b0;
	end

	// exception recording
	always_ff @(posedge MCLK_I)
	begin
		if (!RESETN_I)
		begin
			exception_return_address <= 32'h0000_0000;
			EXC_O                    <= 1'b0;
		end
		else if (CE_I)
		begin
			EXC_O <= take;
			if (take)
				exception_return_address <= INSTR_I.in_delay ? INSTR_I.branch_pc : INSTR_I.pc;
		end
	end

	always_ff @(posedge MCLK_I)
	begin
		if (!RESETN_I)
			watch_held <= 1'b0;
		else if (CE_I)
		begin
			if (INSTR_I.valid & watch_hit & status[cxd_pkg::ST_EXL])
				watch_held <= 1'b1;
			else if (~status[cxd_pkg::ST_EXL])
				watch_held <= 1'b0;
		end
	end

	always_ff @(posedge MCLK_I)
	begin
		if (!RESETN_I)
		begin
			CACHE_EXC_O  <= 1'b0;
			WATCH_PEND_O <= 1'b0;
		end
		else if (CE_I)
		begin
			CACHE_EXC_O  <= CACHE_ERR_I & ~status[cxd_pkg::ST_DE] & ~status[cxd_pkg::ST_ERL];
			WATCH_PEND_O <= watch_held;
		end
	end

	// axi4-lite slave
	assign wr_go = aw_have & w_have & ~BVALID_O;
	always_comb
	begin
		wmask = 32'h0000_0000;
		for (int i = 0; i < 4; i++)
			wmask[8*i +: 8] = {8{w_s[i]}};
	end

	always_ff @(posedge MCLK_I)
	begin
		if (!RESETN_I)
		begin
			aw_have   <= 1'b0;
			w_have    <= 1'b0;
			aw_a      <= 8'h00;
			w_d       <= 32'h0000_0000;
			w_s       <= 4'h0;
			AWREADY_O <= 1'b0;
			WREADY_O  <= 1'b0;
			BVALID_O  <= 1'b0;
			BRESP_O   <= cxd_pkg::RESP_OK;
		end
		else if (CE_I)
		begin
			AWREADY_O <= 1'b0;
			WREADY_O  <= 1'b0;
			if (AWVALID_I & ~aw_have & ~AWREADY_O)
			begin
				AWREADY_O <= 1'b1;
				aw_have   <= 1'b1;
				aw_a      <= AWADDR_I;
			end
			if (WVALID_I & ~w_have & ~WREADY_O)
			begin
				WREADY_O <= 1'b1;
				w_have   <= 1'b1;
				w_d      <= WDATA_I;
				w_s      <= WSTRB_I;
			end
			if (wr_go)
			begin
				aw_have  <= 1'b0;
				w_have   <= 1'b0;
				BVALID_O <= 1'b1;
				BRESP_O  <= (aw_a > cxd_pkg::ADDR_MATCHHI || aw_a[1:0] != 2'h0) ?
					cxd_pkg::RESP_ERR : cxd_pkg::RESP_OK;
			end
			else if (BREADY_I)
				BVALID_O <= 1'b0;
		end
	end

	always_ff @(posedge MCLK_I)
	begin
		if (!RESETN_I)
		begin
			status             <= cxd_pkg::STATUS_RST;
			match_address_low  <= 32'h0000_0000;
			match_address_high <= 32'h0000_0000;
		end
		else if (CE_I)
		begin
			if (wr_go && aw_a == cxd_pkg::ADDR_STATUS)
				status <= (status & ~wmask) | (w_d & wmask);
			// an exception taken beside a status write still sets exl
			if (take)
				status[cxd_pkg::ST_EXL] <= 1'b1;
			if (wr_go && aw_a == cxd_pkg::ADDR_MATCHLO)
				match_address_low <= (match_address_low & ~wmask) | (w_d & wmask);
			if (wr_go && aw_a == cxd_pkg::ADDR_MATCHHI)
				match_address_high <= (match_address_high & ~wmask) | (w_d & wmask);
		end
	end

	// cause: hardware-captured fields; only soft request bits are writable
	always_ff @(posedge MCLK_I)
	begin
		if (!RESETN_I)
			cause <= 32'h0000_0000;
		else if (CE_I)
		begin
			if (wr_go && aw_a == cxd_pkg::ADDR_CAUSE && w_s[1])
				cause[cxd_pkg::CA_IP +: 2] <= w_d[cxd_pkg::CA_IP +: 2];
			if (take)
			begin
				cause[cxd_pkg::CA_CODE +: 5] <= next_code;
				cause[cxd_pkg::CA_BD]        <= INSTR_I.in_delay;
				if (next_code == cxd_pkg::CODE_CPU)
					cause[cxd_pkg::CA_CE +: 2] <= INSTR_I.instr[27:26];
			end
		end
	end

	always_comb
	begin
		next_rdata = 32'h0000_0000;
		case (ARADDR_I)
			cxd_pkg::ADDR_STATUS:  next_rdata = status;
			cxd_pkg::ADDR_CAUSE:   next_rdata = {cause[31:16], pending_request_bits, cause[7:0]};
			cxd_pkg::ADDR_RETADDR: next_rdata = exception_return_address;
			cxd_pkg::ADDR_MATCHLO: next_rdata = match_address_low;
			cxd_pkg::ADDR_MATCHHI: next_rdata = match_address_high;
			default:               next_rdata = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge MCLK_I)
	begin
		if (!RESETN_I)
		begin
			ARREADY_O <= 1'b0;
			RVALID_O  <= 1'b0;
			RDATA_O   <= 32'h0000_0000;
			RRESP_O   <= cxd_pkg::RESP_OK;
		end
		else if (CE_I)
		begin
			ARREADY_O <= 1'b0;
			// read data only follows a completed address handshake
			if (ARVALID_I & ARREADY_O)
			begin
				RVALID_O  <= 1'b1;
				RDATA_O   <= next_rdata;
				RRESP_O   <= (ARADDR_I > cxd_pkg::ADDR_MATCHHI || ARADDR_I[1:0] != 2'h0) ?
					cxd_pkg::RESP_ERR : cxd_pkg::RESP_OK;
			end
			else if (ARVALID_I & ~RVALID_O)
				ARREADY_O <= 1'b1;
			else if (RVALID_O & RREADY_I)
				RVALID_O <= 1'b0;
		end
	end

	// checks
	a_ri_code: assert property (@(posedge MCLK_I) disable iff (!RESETN_I)
		CE_I & take & ~int_take & ~INSTR_I.cop_unusable & undef_op
		|=> cause[6:2] == cxd_pkg::CODE_RI)
		else $error("reserved opcode code not recorded");
	a_ret_slot: assert property (@(posedge MCLK_I) disable iff (!RESETN_I)
		CE_I & take & INSTR_I.in_delay |=> exception_return_address == $past(INSTR_I.branch_pc)
		&& cause[31])
		else $error("delay slot return address wrong");
	a_kernel_dword: assert property (@(posedge MCLK_I) disable iff (!RESETN_I)
		status[4:3] == 2'h0 |-> !dword_bad)
		else $error("kernel doubleword flagged");
	a_watch_cache: assert property (@(posedge MCLK_I) disable iff (!RESETN_I)
		INSTR_I.is_cache |-> !watch_hit)
		else $error("cache op raised watch");
	a_watch_hold: assert property (@(posedge MCLK_I) disable iff (!RESETN_I)
		CE_I & INSTR_I.valid & watch_hit & status[1] |=> watch_held)
		else $error("watch not held under exl");
	a_int_mask: assert property (@(posedge MCLK_I) disable iff (!RESETN_I)
		!status[0] || status[1] || status[2] |-> !int_take)
		else $error("interrupt not masked");
	a_trap_code: assert property (@(posedge MCLK_I) disable iff (!RESETN_I)
		CE_I & take & (next_code == cxd_pkg::CODE_TRAP) |=> EXC_O && cause[6:2] == cxd_pkg::CODE_TRAP)
		else $error("trap not recorded");
	a_cache_mask: assert property (@(posedge MCLK_I) disable iff (!RESETN_I)
		CE_I & (status[16] | status[2]) |=> !CACHE_EXC_O)
		else $error("cache error not suppressed");
	c_int: cover property (@(posedge MCLK_I) disable iff (!RESETN_I) int_take & take);
	c_watch: cover property (@(posedge MCLK_I) disable iff (!RESETN_I) take & (next_code == cxd_pkg::CODE_WATCH));
	c_ovf: cover property (@(posedge MCLK_I) disable iff (!RESETN_I) take & (next_code == cxd_pkg::CODE_OVF));
endmodule

//--- hdl/cxd_pkg.sv
package cxd_pkg;
	// cause codes: distinct values, encodings are arbitrary
	localparam logic [4:0] CODE_INT   = 5'h00;
	localparam logic [4:0] CODE_CPU   = 5'h0B;
	localparam logic [4:0] CODE_RI    = 5'h0A;
	localparam logic [4:0] CODE_TRAP  = 5'h0D;
	localparam logic [4:0] CODE_OVF   = 5'h0C;
	localparam logic [4:0] CODE_WATCH = 5'h17;
	// register byte addresses
	localparam logic [7:0] ADDR_STATUS   = 8'h00;
	localparam logic [7:0] ADDR_CAUSE    = 8'h04;
	localparam logic [7:0] ADDR_RETADDR  = 8'h08;
	localparam logic [7:0] ADDR_MATCHLO  = 8'h0C;
	localparam logic [7:0] ADDR_MATCHHI  = 8'h10;
	// status fields
	localparam int ST_IE  = 0;
	localparam int ST_EXL = 1;
	localparam int ST_ERL = 2;
	localparam int ST_KSU = 3;
	localparam int ST_UX  = 5;
	localparam int ST_IM  = 8;
	localparam int ST_DE  = 16;
	localparam logic [31:0] STATUS_RST = 32'h0000_0004;
	// cause fields
	localparam int CA_CODE = 2;
	localparam int CA_IP   = 8;
	localparam int CA_CE   = 28;
	localparam int CA_BD   = 31;
	// match low fields
	localparam int ML_W = 0;
	localparam int ML_R = 1;
	localparam logic [1:0] RESP_OK  = 2'h0;
	localparam logic [1:0] RESP_ERR = 2'h2;
	typedef enum logic [1:0] {M_KERNEL, M_SUPER, M_USER, M_BAD} cxd_mode_e;
	typedef struct packed {
		logic        valid;
		logic [31:0] instr;
		logic [31:0] pc;
		logic        in_delay;
		logic [31:0] branch_pc;
		logic        is_load;
		logic        is_store;
		logic        is_cache;
		logic [35:0] paddr;
		logic        trap_true;
		logic        ovf;
		logic        cop_unusable;
	} cxd_instr_s;
endpackage

//--- verif/cxd_pipe.sv
`timescale 1ns/100ps
module cxd_pipe
(
	// clock
	input  wire logic                clk_i,
	// core side
	input  wire logic                exc_i,
	output      cxd_pkg::cxd_instr_s instr_o,
	output      logic [4:0]          hw_o,
	output      logic                timer_o
);
	initial
	begin
		instr_o = '0;
		hw_o = '0;
		timer_o = 1'b0;
	end
	// fields are inverted after use so a stale word can never pass for a fresh one
	task automatic issue(input cxd_pkg::cxd_instr_s s, output logic got);
		cxd_pkg::cxd_instr_s t;
		t = ~s;
		t.valid = 1'b0;
		@(posedge clk_i);
		instr_o <= s;
		@(posedge clk_i);
		instr_o <= t;
		#1 got = exc_i;
	endtask
	// a source holds its line until the bench says it was serviced
	task automatic req(input logic [5:0] r);
		@(posedge clk_i);
		{timer_o, hw_o} <= r;
	endtask
endmodule

//--- verif/test_cxd_top.sv
`timescale 1ns/100ps
`define CHK(g, e) \
	begin \
		total_checks++; \
		if ((g) !== (e)) \
		begin \
			n_mismatch++; \
			$display("MISMATCH t=%0t got %0h exp %0h", $time, (g), (e)); \
		end \
	end
module test_cxd_top;
	logic        mclk = 1'b0;
	logic        resetn = 1'b0;
	logic        ce = 1'b1;
	logic        cerr = 1'b0;
	logic [7:0]  awaddr = '0;
	logic [7:0]  araddr = '0;
	logic [31:0] wdata = '0;
	logic [3:0]  wstrb = '0;
	logic        awvalid = 1'b0;
	logic        wvalid = 1'b0;
	logic        bready = 1'b0;
	logic        arvalid = 1'b0;
	logic        rready = 1'b0;
	logic        awready, wready, bvalid, arready, rvalid, exc, cexc, wpend, tmr, dly, g;
	logic [1:0]  bresp, rresp, r;
	logic [4:0]  hw;
	logic [31:0] rdata, d, pc, st;
	logic [35:0] pa;
	logic [31:0] mtab [4] = '{32'h0000_FB01, 32'h0000_FF00, 32'h0000_FF05, 32'h0000_FF03};
	logic [31:0] ctab [3] = '{32'h0000_FF01, 32'h0001_FF01, 32'h0000_FF05};
	cxd_pkg::cxd_instr_s ins;
	int          i, j, n_mismatch = 0, total_checks = 0;

	always #50 mclk = ~mclk;

	cxd_top u_cxd_top (.MCLK_I(mclk), .RESETN_I(resetn), .CE_I(ce), .INSTR_I(ins),
		.CACHE_ERR_I(cerr), .HW_REQ_I(hw), .TIMER_REQ_I(tmr), .AWADDR_I(awaddr),
		.AWVALID_I(awvalid), .AWREADY_O(awready), .WDATA_I(wdata), .WSTRB_I(wstrb),
		.WVALID_I(wvalid), .WREADY_O(wready), .BRESP_O(bresp), .BVALID_O(bvalid),
		.BREADY_I(bready), .ARADDR_I(araddr), .ARVALID_I(arvalid), .ARREADY_O(arready),
		.RDATA_O(rdata), .RRESP_O(rresp), .RVALID_O(rvalid), .RREADY_I(rready),
		.EXC_O(exc), .CACHE_EXC_O(cexc), .WATCH_PEND_O(wpend));
	cxd_pipe u_cxd_pipe (.clk_i(mclk), .exc_i(exc), .instr_o(ins), .hw_o(hw), .timer_o(tmr));

	task automatic final_report;
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [3:0] s = 4'hF);
		@(posedge mclk);
		awaddr <= a;
		wdata <= v;
		wstrb <= s;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do
		begin
			@(posedge mclk);
			awvalid <= awvalid & ~awready;
			wvalid <= wvalid & ~wready;
		end
		while (!bvalid);
		r = bresp;
		bready <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a);
		@(posedge mclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do
		begin
			@(posedge mclk);
			arvalid <= arvalid & ~arready;
		end
		while (!rvalid);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask

	// flag order: coprocessor, overflow, trap, cache op, store, load
	function automatic cxd_pkg::cxd_instr_s mk(input logic [31:0] w, input logic [5:0] f);
		mk = '0;
		mk.valid = 1'b1;
		mk.instr = w;
		mk.pc = pc;
		mk.branch_pc = pc - 32'h4;
		mk.in_delay = dly;
		mk.paddr = pa;
		{mk.cop_unusable, mk.ovf, mk.trap_true, mk.is_cache, mk.is_store, mk.is_load} = f;
	endfunction

	// requests are dropped before the status write so nothing re-fires behind our back
	task automatic xc(input logic [31:0] w, input logic [5:0] f, input logic e,
		input logic [4:0] c);
		pc = pc + 32'h100;
		u_cxd_pipe.issue(mk(w, f), g);
		`CHK(g, e)
		if (e)
		begin
			rd(cxd_pkg::ADDR_CAUSE);
			`CHK(d[6:2], c)
			`CHK(d[31], dly)
			rd(cxd_pkg::ADDR_RETADDR);
			`CHK(d, dly ? pc - 32'h4 : pc)
		end
		u_cxd_pipe.req(6'h00);
		wr(cxd_pkg::ADDR_CAUSE, 32'h0, 4'h2);
		wr(cxd_pkg::ADDR_STATUS, st);
	endtask

	initial
	begin
		#2000000;
		n_mismatch++;
		final_report();
	end

	initial
	begin
		pc = 32'h0000_1000;
		dly = 1'b0;
		pa = '0;
		repeat (4) @(posedge mclk);
		resetn <= 1'b1;
		st = 32'h0000_FF01;
		wr(cxd_pkg::ADDR_STATUS, st);
		`CHK(r, cxd_pkg::RESP_OK)
		xc(32'hEC00_0000, 6'h00, 1'b1, cxd_pkg::CODE_RI);
		xc(32'h0000_0005, 6'h00, 1'b1, cxd_pkg::CODE_RI);
		dly = 1'b1;
		xc(32'h0404_0000, 6'h00, 1'b1, cxd_pkg::CODE_RI);
		dly = 1'b0;
		xc(32'h0000_002C, 6'h10, 1'b1, cxd_pkg::CODE_OVF);
		for (i = 0; i < 2; i++)
		begin
			st = i ? 32'h0000_FF11 : 32'h0000_FF09;
			wr(cxd_pkg::ADDR_STATUS, st);
			xc(32'h0000_002C, 6'h00, 1'b1, cxd_pkg::CODE_RI);
		end
		st = 32'h0000_FF01;
		wr(cxd_pkg::ADDR_STATUS, st);
		xc(32'h0000_0034, 6'h08, 1'b1, cxd_pkg::CODE_TRAP);
		xc(32'h4A00_0000, 6'h28, 1'b1, cxd_pkg::CODE_CPU);
		rd(cxd_pkg::ADDR_CAUSE);
		`CHK(d[29:28], 2'h2)
		xc(32'h0000_0034, 6'h18, 1'b1, cxd_pkg::CODE_TRAP);
		xc(32'hEC00_0000, 6'h08, 1'b1, cxd_pkg::CODE_RI);
		for (i = 0; i < 6; i++)
		begin
			u_cxd_pipe.req(6'h01 << i);
			rd(cxd_pkg::ADDR_CAUSE);
			`CHK(d[15:8], i < 5 ? 8'h04 << i : 8'h80)
			xc(32'h0, 6'h00, 1'b1, cxd_pkg::CODE_INT);
		end
		for (i = 0; i < 2; i++)
		begin
			wr(cxd_pkg::ADDR_CAUSE, 32'h100 << i, 4'h2);
			rd(cxd_pkg::ADDR_CAUSE);
			`CHK(d[9:8], 2'h1 << i)
			xc(32'h0, 6'h00, 1'b1, cxd_pkg::CODE_INT);
			rd(cxd_pkg::ADDR_CAUSE);
			`CHK(d[9:8], 2'h0)
		end
		for (i = 0; i < 4; i++)
		begin
			st = mtab[i];
			wr(cxd_pkg::ADDR_STATUS, st);
			u_cxd_pipe.req(6'h01);
			rd(cxd_pkg::ADDR_CAUSE);
			`CHK(d[10], 1'b1)
			xc(32'h0, 6'h00, 1'b0, 5'h00);
		end
		for (i = 0; i < 3; i++)
		begin
			wr(cxd_pkg::ADDR_STATUS, ctab[i]);
			@(posedge mclk);
			cerr <= 1'b1;
			@(posedge mclk);
			cerr <= 1'b0;
			#1;
			`CHK(cexc, i == 0)
		end
		st = 32'h0000_FF01;
		wr(cxd_pkg::ADDR_STATUS, st);
		pa = 36'h5_0000_1238;
		wr(cxd_pkg::ADDR_MATCHHI, 32'h5);
		for (i = 1; i < 4; i++)
			for (j = 0; j < 2; j++)
			begin
				wr(cxd_pkg::ADDR_MATCHLO, 32'h0000_1238 | i);
				xc(j ? 32'hAC00_0000 : 32'h8C00_0000, j ? 6'h02 : 6'h01,
					j ? i[0] : i[1], cxd_pkg::CODE_WATCH);
			end
		xc(32'hBC00_0000, 6'h05, 1'b0, 5'h00);
		xc(32'h8C00_0000, 6'h11, 1'b1, cxd_pkg::CODE_OVF);
		pa = 36'h4_0000_1238;
		xc(32'h8C00_0000, 6'h01, 1'b0, 5'h00);
		pa = 36'h5_0000_1238;
		rd(8'h14);
		`CHK({r, d}, {cxd_pkg::RESP_ERR, 32'h0})
		wr(8'h14, 32'h0);
		`CHK(r, cxd_pkg::RESP_ERR)
		ce <= 1'b0;
		u_cxd_pipe.issue(mk(32'hEC00_0000, 6'h00), g);
		ce <= 1'b1;
		`CHK(g, 1'b0)
		wr(cxd_pkg::ADDR_STATUS, st | 32'h2);
		u_cxd_pipe.issue(mk(32'h8C00_0000, 6'h01), g);
		@(posedge mclk);
		#1;
		`CHK({g, wpend}, 2'b01)
		final_report();
	end
endmodule
